// ### hw/exec_pkg.sv
/*
 * Shared constants and types for the 8-bit execute stage: status flag
 * positions, cycle counts, program counter steps and the operation codes.
 * Assumes the decoder outside maps each fetched instruction to one op_e value.
 */
package exec_pkg;

    // Status flag bit positions, bit 7 down to bit 0: I T H S V N Z C
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;

    // Status flags after reset
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // Execution lengths in clocks
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // Program counter steps
    localparam logic [15:0] PC_STEP     = 16'h0001;
    localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
    localparam logic [15:0] PC_SKIP_TWO = 16'h0003;

    // Operations carried out by the execute stage
    typedef enum logic [4:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SUBB, OP_SUBK, OP_SUBBK,
        OP_CP, OP_CPC, OP_CPK,
        OP_AND, OP_ANDK, OP_OR, OP_ORK, OP_EOR, OP_SETB, OP_CLRB, OP_TEST,
        OP_WADD, OP_WSUB,
        OP_IJUMP, OP_CALLZ,
        OP_CPSKIP, OP_SKRC, OP_SKRS, OP_SKIC, OP_SKIS,
        OP_BRSET, OP_BRCLR, OP_NOP
    } op_e;

    // Byte operation of the arithmetic unit
    typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_EOR} alu_e;

    // Sequencer states
    typedef enum logic {ST_IDLE, ST_BUSY} st_e;

endpackage

// ### hw/alu8.sv
/*
 * Combinational 8-bit arithmetic and logic unit with raw flag outputs.
 * Assumes the caller picks which of the flags it keeps.
 */
`timescale 1ns/1ps
`default_nettype none

module alu8 (
    input  wire logic [7:0]       a,
    input  wire logic [7:0]       b,
    input  wire logic             cin,
    input  wire exec_pkg::alu_e   mode,
    output logic      [7:0]       res,
    output logic                  c,
    output logic                  h,
    output logic                  v,
    output logic                  n,
    output logic                  z
);

    logic [8:0] sum;
    logic [8:0] dif;

    // Carry chains of the adder and the subtractor
    assign sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign dif = {1'b0, a} - {1'b0, b} - {8'h00, cin};

    // Result select
    always_comb begin
        case (mode)
            exec_pkg::ALU_ADD: res = sum[7:0];
            exec_pkg::ALU_SUB: res = dif[7:0];
            exec_pkg::ALU_AND: res = a & b;
            exec_pkg::ALU_OR:  res = a | b;
            default:           res = a ^ b;
        endcase
    end

    // Carry, half carry and overflow from operand and result bits 7 and 3; add carry from sum[8]
    always_comb begin
        c = 1'b0;
        h = 1'b0;
        v = 1'b0;
        if (mode == exec_pkg::ALU_ADD) begin
            c = sum[8];
            h = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
            v = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
        end else if (mode == exec_pkg::ALU_SUB) begin
            c = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
            h = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
            v = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
        end
    end

    assign n = res[7];
    assign z = (res == 8'h00);

endmodule

`default_nettype wire

// ### hw/risc8_alu_branch_exec.sv
/*
 * Execute stage of an 8-bit core: arithmetic, logic, compare, skip, branch
 * and indirect jump/call, with the status flag register kept here.
 * Assumes the fetch logic presents one decoded operation with its operand
 * values, holds it until ready, and takes pc_new_r when done_r pulses.
 */
// How it works
// - Add with carry writes rd plus rr plus carry; sets Z C N V H; one clock
// - Subtract with borrow writes rd minus rr minus carry; sets Z C N V H; one clock
// - Word add adds constant to register pair; sets Z C N V S; two clocks
// - Word subtract takes constant from register pair; sets Z C N V S; two clocks
// - Subtract immediate writes rd minus constant; sets Z C N V H; one clock
// - Subtract immediate with borrow writes rd minus constant minus carry; one clock
// - AND immediate writes rd and constant; sets only Z N V; one clock
// - OR immediate writes rd or constant; sets only Z N V; one clock
// - Set bits ORs a mask into rd; sets only Z N V; one clock
// - Clear bits ANDs rd with inverted mask; sets only Z N V; one clock
// - Test ANDs rd with itself, value kept; sets Z N V; one clock
// - Indirect jump loads PC from the Z pointer; no flags; two clocks
// - Indirect call pushes return address, PC from Z pointer; three clocks
// - Compare skip equal skips next instruction when registers match; one to three clocks
// - Compare immediate sets Z N V C H from rd minus constant; nothing stored
// - Register bit skips skip when chosen bit is clear or set; flags kept
// - I/O bit skips skip when chosen I/O bit is clear or set; flags kept
// - Branch on flag set adds offset plus one when status bit is one
// - Branch on flag clear adds offset plus one when status bit is zero
`timescale 1ns/1ps
`default_nettype none

module risc8_alu_branch_exec #(
    parameter int PC_W = 16
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               op_valid,
    input  wire exec_pkg::op_e      op_in,
    input  wire logic [7:0]         rd_val,
    input  wire logic [7:0]         rdh_val,
    input  wire logic [7:0]         rr_val,
    input  wire logic [7:0]         imm,
    input  wire logic [7:0]         io_val,
    input  wire logic [2:0]         bit_sel,
    input  wire logic [6:0]         offset,
    input  wire logic [15:0]        z_ptr,
    input  wire logic [PC_W-1:0]    pc_in,
    input  wire logic               next_two_word,
    output logic                    ready,
    output logic                    done_r,
    output logic                    res_we_r,
    output logic                    res_hi_we_r,
    output logic [7:0]              res_lo_r,
    output logic [7:0]              res_hi_r,
    output logic [7:0]              flags_r,
    output logic [PC_W-1:0]         pc_new_r,
    output logic                    push_we_r,
    output logic [PC_W-1:0]         push_data_r
);

    exec_pkg::st_e   state_r;
    logic [1:0]      remain_r;
    logic            take;
    exec_pkg::alu_e  alu_mode;
    logic [7:0]      alu_b;
    logic            alu_cin;
    logic [7:0]      alu_res;
    logic            a_c, a_h, a_v, a_n, a_z;

    // Operation classes
    logic is_arith, is_chain, is_cmp, is_logic, is_word, is_imm, is_skip, is_branch;
    assign is_arith  = op_in inside {exec_pkg::OP_ADD, exec_pkg::OP_ADC, exec_pkg::OP_SUB,
                                     exec_pkg::OP_SUBB, exec_pkg::OP_SUBK, exec_pkg::OP_SUBBK,
                                     exec_pkg::OP_CP, exec_pkg::OP_CPC, exec_pkg::OP_CPK};
    assign is_chain  = op_in inside {exec_pkg::OP_SUBB, exec_pkg::OP_SUBBK, exec_pkg::OP_CPC};
    assign is_cmp    = op_in inside {exec_pkg::OP_CP, exec_pkg::OP_CPC, exec_pkg::OP_CPK};
    assign is_logic  = op_in inside {exec_pkg::OP_AND, exec_pkg::OP_ANDK, exec_pkg::OP_OR,
                                     exec_pkg::OP_ORK, exec_pkg::OP_EOR, exec_pkg::OP_SETB,
                                     exec_pkg::OP_CLRB, exec_pkg::OP_TEST};
    assign is_word   = op_in inside {exec_pkg::OP_WADD, exec_pkg::OP_WSUB};
    assign is_imm    = op_in inside {exec_pkg::OP_SUBK, exec_pkg::OP_SUBBK, exec_pkg::OP_CPK,
                                     exec_pkg::OP_ANDK, exec_pkg::OP_ORK, exec_pkg::OP_SETB};
    assign is_skip   = op_in inside {exec_pkg::OP_CPSKIP, exec_pkg::OP_SKRC, exec_pkg::OP_SKRS,
                                     exec_pkg::OP_SKIC, exec_pkg::OP_SKIS};
    assign is_branch = op_in inside {exec_pkg::OP_BRSET, exec_pkg::OP_BRCLR};

    // Byte unit mode, operand and carry select
    assign alu_mode = (op_in inside {exec_pkg::OP_ADD, exec_pkg::OP_ADC}) ? exec_pkg::ALU_ADD :
                      is_arith ? exec_pkg::ALU_SUB :
                      (op_in inside {exec_pkg::OP_OR, exec_pkg::OP_ORK, exec_pkg::OP_SETB}) ? exec_pkg::ALU_OR :
                      (op_in == exec_pkg::OP_EOR) ? exec_pkg::ALU_EOR : exec_pkg::ALU_AND;
    assign alu_b    = (op_in == exec_pkg::OP_CLRB) ? ~imm :
                      (op_in == exec_pkg::OP_TEST) ? rd_val :
                      is_imm ? imm : rr_val;
    assign alu_cin  = (is_chain || op_in == exec_pkg::OP_ADC) ? flags_r[exec_pkg::FLAG_C] : 1'b0;

    alu8 u_alu (
        .a    (rd_val),
        .b    (alu_b),
        .cin  (alu_cin),
        .mode (alu_mode),
        .res  (alu_res),
        .c    (a_c),
        .h    (a_h),
        .v    (a_v),
        .n    (a_n),
        .z    (a_z)
    );

    // Word add or subtract of a constant on the register pair
    logic [15:0] w_in, w_res;
    logic        w_v, w_c;
    assign w_in  = {rdh_val, rd_val};
    assign w_res = (op_in == exec_pkg::OP_WADD) ? w_in + {8'h00, imm} : w_in - {8'h00, imm};
    assign w_v   = (op_in == exec_pkg::OP_WADD) ? (~rdh_val[7] & w_res[15]) : (rdh_val[7] & ~w_res[15]);
    assign w_c   = (op_in == exec_pkg::OP_WADD) ? (~w_res[15] & rdh_val[7]) : (w_res[15] & ~rdh_val[7]);

    // Flag images per class; untouched bits are copied from the register
    logic        z_chain;
    logic [7:0]  fl_arith, fl_logic, fl_word, flags_calc;
    assign z_chain   = is_chain ? (a_z & flags_r[exec_pkg::FLAG_Z]) : a_z;
    assign fl_arith  = {flags_r[7:6], a_h, flags_r[4], a_v, a_n, z_chain, a_c};
    assign fl_logic  = {flags_r[7:4], 1'b0, a_n, a_z, flags_r[0]};
    assign fl_word   = {flags_r[7:5], w_res[15] ^ w_v, w_v, w_res[15], w_res == 16'h0000, w_c};
    assign flags_calc = is_arith ? fl_arith : is_logic ? fl_logic : is_word ? fl_word : flags_r;

    // Skip and branch decisions
    logic skip_hit, br_taken;
    assign skip_hit = (op_in == exec_pkg::OP_CPSKIP && rd_val == rr_val) ||
                      (op_in == exec_pkg::OP_SKRC && !rr_val[bit_sel]) ||
                      (op_in == exec_pkg::OP_SKRS && rr_val[bit_sel]) ||
                      (op_in == exec_pkg::OP_SKIC && !io_val[bit_sel]) ||
                      (op_in == exec_pkg::OP_SKIS && io_val[bit_sel]);
    assign br_taken = (op_in == exec_pkg::OP_BRSET &&  flags_r[bit_sel]) ||
                      (op_in == exec_pkg::OP_BRCLR && !flags_r[bit_sel]);

    // Length and next program counter of the operation being taken
    logic [1:0]      cyc_calc;
    logic [PC_W-1:0] pc_calc, pc_ret;
    assign pc_ret   = pc_in + PC_W'(exec_pkg::PC_STEP);
    assign cyc_calc = (is_word || op_in == exec_pkg::OP_IJUMP) ? exec_pkg::CYC_TWO :
                      (op_in == exec_pkg::OP_CALLZ) ? exec_pkg::CYC_THREE :
                      (is_skip && skip_hit) ? (next_two_word ? exec_pkg::CYC_THREE : exec_pkg::CYC_TWO) :
                      br_taken ? exec_pkg::CYC_TWO : exec_pkg::CYC_ONE;
    assign pc_calc  = (op_in inside {exec_pkg::OP_IJUMP, exec_pkg::OP_CALLZ}) ? PC_W'(z_ptr) :
                      (is_skip && skip_hit) ? pc_in + PC_W'(next_two_word ? exec_pkg::PC_SKIP_TWO
                                                                          : exec_pkg::PC_SKIP_ONE) :
                      br_taken ? pc_ret + PC_W'({{9{offset[6]}}, offset}) : pc_ret;

    // Write enables and result bytes
    logic       we_calc, hi_we_calc;
    logic [7:0] lo_calc, hi_calc;
    assign we_calc    = (is_arith && !is_cmp) || (is_logic && op_in != exec_pkg::OP_TEST) || is_word;
    assign hi_we_calc = is_word;
    assign lo_calc    = is_word ? w_res[7:0] : alu_res;
    assign hi_calc    = w_res[15:8];

    // Handshake and completion timing
    logic fin_now, fin_late, fin;
    assign ready    = (state_r == exec_pkg::ST_IDLE);
    assign take     = op_valid && ready;
    assign fin_now  = take && cyc_calc == exec_pkg::CYC_ONE;
    assign fin_late = (state_r == exec_pkg::ST_BUSY) && remain_r == 2'h1;
    assign fin      = fin_now || fin_late;

    // Results held while a multi-clock operation runs
    logic            p_we, p_hi_we, p_push;
    logic [7:0]      p_lo, p_hi, p_flags;
    logic [PC_W-1:0] p_pc, p_ret;
    always_ff @(posedge core_clk) begin
        if (take) begin
            {p_we, p_hi_we, p_push} <= {we_calc, hi_we_calc, op_in == exec_pkg::OP_CALLZ};
            {p_lo, p_hi, p_flags}   <= {lo_calc, hi_calc, flags_calc};
            {p_pc, p_ret}           <= {pc_calc, pc_ret};
        end
    end

    // Sequencer: idle, or counting the remaining clocks
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r  <= exec_pkg::ST_IDLE;
            remain_r <= 2'h0;
        end else begin
            case (state_r)
                exec_pkg::ST_IDLE: begin
                    if (take && cyc_calc != exec_pkg::CYC_ONE) begin
                        state_r  <= exec_pkg::ST_BUSY;
                        remain_r <= cyc_calc - 2'h1;
                    end
                end
                exec_pkg::ST_BUSY: begin
                    remain_r <= remain_r - 2'h1;
                    if (remain_r == 2'h1) begin
                        state_r <= exec_pkg::ST_IDLE;
                    end
                end
                default: state_r <= exec_pkg::ST_IDLE;
            endcase
        end
    end

    // Completion strobes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {done_r, res_we_r, res_hi_we_r, push_we_r} <= 4'h0;
        end else begin
            done_r      <= fin;
            res_we_r    <= fin && (fin_now ? we_calc : p_we);
            res_hi_we_r <= fin_late && p_hi_we;
            push_we_r   <= fin_late && p_push;
        end
    end

    // Result, flag and program counter registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags_r     <= exec_pkg::FLAGS_RESET;
            res_lo_r    <= 8'h00;
            res_hi_r    <= 8'h00;
            pc_new_r    <= '0;
            push_data_r <= '0;
        end else if (fin) begin
            flags_r     <= fin_now ? flags_calc : p_flags;
            res_lo_r    <= fin_now ? lo_calc : p_lo;
            res_hi_r    <= fin_now ? hi_calc : p_hi;
            pc_new_r    <= fin_now ? pc_calc : p_pc;
            push_data_r <= fin_now ? pc_ret : p_ret;
        end
    end

    // Reference values for the checks below
    logic [8:0] chk_adc;
    logic [7:0] chk_subb, chk_subk, chk_subbk;
    assign chk_adc   = {1'b0, rd_val} + {1'b0, rr_val} + {8'h00, flags_r[exec_pkg::FLAG_C]};
    assign chk_subb  = rd_val - rr_val - {7'h00, flags_r[exec_pkg::FLAG_C]};
    assign chk_subk  = rd_val - imm;
    assign chk_subbk = rd_val - imm - {7'h00, flags_r[exec_pkg::FLAG_C]};

    property p_adc;
        @(posedge core_clk) disable iff (rst)
        (take && op_in == exec_pkg::OP_ADC) |=> done_r && res_we_r && res_lo_r == $past(chk_adc[7:0])
            && flags_r[exec_pkg::FLAG_C] == $past(chk_adc[8]);
    endproperty
    a_adc: assert property (p_adc) else $error("add with carry result wrong");

    property p_subb;
        @(posedge core_clk) disable iff (rst)
        (take && op_in == exec_pkg::OP_SUBB) |=> done_r && res_we_r && res_lo_r == $past(chk_subb)
            && flags_r[exec_pkg::FLAG_Z] == ($past(flags_r[exec_pkg::FLAG_Z]) && $past(chk_subb) == 8'h00);
    endproperty
    a_subb: assert property (p_subb) else $error("subtract with borrow result wrong");

    property p_word;
        @(posedge core_clk) disable iff (rst)
        (take && is_word) |=> !done_r ##1 (done_r && res_hi_we_r && {res_hi_r, res_lo_r} == $past(w_res, 2));
    endproperty
    a_word: assert property (p_word) else $error("word operation timing or value wrong");

    property p_subk;
        @(posedge core_clk) disable iff (rst)
        (take && op_in == exec_pkg::OP_SUBK) |=> done_r && res_lo_r == $past(chk_subk);
    endproperty
    a_subk: assert property (p_subk) else $error("subtract immediate result wrong");

    property p_subbk;
        @(posedge core_clk) disable iff (rst)
        (take && op_in == exec_pkg::OP_SUBBK) |=> done_r && res_lo_r == $past(chk_subbk);
    endproperty
    a_subbk: assert property (p_subbk) else $error("subtract immediate with borrow wrong");

    property p_logic_keep;
        @(posedge core_clk) disable iff (rst)
        (take && is_logic) |=> done_r && !flags_r[exec_pkg::FLAG_V]
            && $stable(flags_r[exec_pkg::FLAG_C]) && $stable(flags_r[exec_pkg::FLAG_H]);
    endproperty
    a_logic_keep: assert property (p_logic_keep) else $error("logic op touched carry or half carry");

    property p_test;
        @(posedge core_clk) disable iff (rst)
        (take && op_in == exec_pkg::OP_TEST) |=> !res_we_r && flags_r[exec_pkg::FLAG_Z] == ($past(rd_val) == 8'h00);
    endproperty
    a_test: assert property (p_test) else $error("test wrote register or wrong zero");

    property p_ijump;
        @(posedge core_clk) disable iff (rst)
        (take && op_in == exec_pkg::OP_IJUMP) |=> !done_r ##1 (done_r && pc_new_r == $past(z_ptr, 2) && $stable(flags_r));
    endproperty
    a_ijump: assert property (p_ijump) else $error("indirect jump wrong");

    property p_callz;
        @(posedge core_clk) disable iff (rst)
        (take && op_in == exec_pkg::OP_CALLZ) |=> !done_r [*2] ##1 (done_r && push_we_r && pc_new_r == $past(z_ptr, 3));
    endproperty
    a_callz: assert property (p_callz) else $error("indirect call wrong");

    property p_cmp_imm;
        @(posedge core_clk) disable iff (rst)
        (take && op_in == exec_pkg::OP_CPK) |=> done_r && !res_we_r
            && flags_r[exec_pkg::FLAG_Z] == ($past(rd_val) == $past(imm));
    endproperty
    a_cmp_imm: assert property (p_cmp_imm) else $error("compare immediate wrong");

    property p_skip;
        @(posedge core_clk) disable iff (rst)
        (take && is_skip && skip_hit && next_two_word) |=> !done_r [*2] ##1 (done_r && pc_new_r == $past(pc_in, 3) + 16'h0003);
    endproperty
    a_skip: assert property (p_skip) else $error("skip over two-word instruction wrong");

    property p_branch;
        @(posedge core_clk) disable iff (rst)
        (take && is_branch && !br_taken) |=> done_r && pc_new_r == $past(pc_ret) && $stable(flags_r);
    endproperty
    a_branch: assert property (p_branch) else $error("untaken branch wrong");

endmodule

`default_nettype wire

// ### tb/fetch_model.sv
/*
 * Fetch-side model: offers one decoded operation with its operands, holds it until taken,
 * then measures clocks to completion and captures the write and push strobes.
 * Assumes the execute stage answers with done_r within a few clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module fetch_model (
    input  wire logic          core_clk,
    input  wire logic          ready,
    input  wire logic          done_r,
    input  wire logic          res_we_r,
    input  wire logic          res_hi_we_r,
    input  wire logic          push_we_r,
    output var logic           op_valid,
    output var exec_pkg::op_e  op_in,
    output var logic [7:0]     rd_val,
    output var logic [7:0]     rdh_val,
    output var logic [7:0]     rr_val,
    output var logic [7:0]     imm,
    output var logic [7:0]     io_val,
    output var logic [2:0]     bit_sel,
    output var logic [6:0]     offset,
    output var logic [15:0]    z_ptr,
    output var logic [15:0]    pc_in,
    output var logic           next_two_word
);
    localparam logic [15:0] PC0 = 16'h0100;
    logic [2:0] lat;
    logic       we;
    logic       hw;
    logic       pw;

    // Drives every request line at once
    function automatic void put(exec_pkg::op_e op, logic v, logic [7:0] a, logic [7:0] b, logic [7:0] k,
                                logic [2:0] s, logic [6:0] o, logic [15:0] z, logic [7:0] h,
                                logic [7:0] p, logic [15:0] c, logic tw);
        op_valid = v;
        op_in = op;
        rd_val = a;
        rr_val = b;
        imm = k;
        bit_sel = s;
        offset = o;
        z_ptr = z;
        rdh_val = h;
        io_val = p;
        pc_in = c;
        next_two_word = tw;
    endfunction

    initial put(exec_pkg::OP_NOP, 1'b0, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 16'h0000, 8'h00, 8'h00, 16'h0000, 1'b0);

    // One request: hold until ready at an edge, then count clocks to done
    task automatic issue(input exec_pkg::op_e op, input logic [7:0] a = 8'h00, input logic [7:0] b = 8'h00,
                         input logic [7:0] k = 8'h00, input logic [2:0] s = 3'h0, input logic [6:0] o = 7'h00,
                         input logic [15:0] z = 16'h0000, input logic [7:0] h = 8'h00,
                         input logic [7:0] p = 8'h00, input logic tw = 1'b0);
        int n;
        @(posedge core_clk);
        #1;
        put(op, 1'b1, a, b, k, s, o, z, h, p, PC0, tw);
        n = 0;
        while (ready !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        #1;
        // Released operand lines carry the inverse so stale operands cannot pass; op_in keeps the operation
        put(op, 1'b0, ~a, ~b, ~k, ~s, ~o, ~z, ~h, ~p, ~PC0, ~tw);
        lat = (n < 8) ? 3'h1 : 3'h7;
        while (done_r !== 1'b1 && lat < 3'h6) begin
            @(posedge core_clk);
            #1;
            lat++;
        end
        we = res_we_r;
        hw = res_hi_we_r;
        pw = push_we_r;
    endtask
endmodule

`default_nettype wire

// ### tb/tb.sv
/*
 * Self-checking bench for the execute stage: arithmetic, logic, word, branch, skip and jump.
 * Assumes fetch_model drives the operation side; expected flags are tracked here.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
    logic          core_clk, rst, op_valid, next_two_word, ready, done_r, res_we_r, res_hi_we_r, push_we_r;
    exec_pkg::op_e op_in;
    logic [7:0]    rd_val, rdh_val, rr_val, imm, io_val, res_lo_r, res_hi_r, flags_r, ef;
    logic [2:0]    bit_sel;
    logic [6:0]    offset;
    logic [15:0]   z_ptr, pc_in, pc_new_r, push_data_r;
    int            checks, miscompares;

    risc8_alu_branch_exec #(.PC_W(16)) uut (.core_clk, .rst, .op_valid, .op_in, .rd_val, .rdh_val, .rr_val,
        .imm, .io_val, .bit_sel, .offset, .z_ptr, .pc_in, .next_two_word, .ready, .done_r, .res_we_r,
        .res_hi_we_r, .res_lo_r, .res_hi_r, .flags_r, .pc_new_r, .push_we_r, .push_data_r);
    fetch_model u_fetch (.core_clk, .ready, .done_r, .res_we_r, .res_hi_we_r, .push_we_r, .op_valid, .op_in,
        .rd_val, .rdh_val, .rr_val, .imm, .io_val, .bit_sel, .offset, .z_ptr, .pc_in, .next_two_word);

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #2000000;
        miscompares++;
        give_verdict;
    end

    task give_verdict;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Judges the last completed operation against expected values
    task exp(input logic [2:0] l, input logic w, input logic hw, input logic pw, input logic [7:0] lo,
             input logic [15:0] pc);
        `CHK(u_fetch.lat, l)
        `CHK(u_fetch.we, w)
        `CHK(u_fetch.hw, hw)
        `CHK(u_fetch.pw, pw)
        if (w) `CHK(res_lo_r, lo)
        `CHK(flags_r, ef)
        `CHK(pc_new_r, pc)
        if (u_fetch.lat > 3'h5) give_verdict;
    endtask

    task t_arith;
        ef = 8'h25;
        u_fetch.issue(exec_pkg::OP_SUBK, 8'h00, 8'h00, 8'h01);
        exp(3'h1, 1'b1, 1'b0, 1'b0, 8'hff, 16'h0101);
        ef = 8'h2c;
        u_fetch.issue(exec_pkg::OP_ADC, 8'h0f, 8'h70);
        exp(3'h1, 1'b1, 1'b0, 1'b0, 8'h80, 16'h0101);
        ef = 8'h02;
        u_fetch.issue(exec_pkg::OP_CPK, 8'h42, 8'h00, 8'h42);
        exp(3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0101);
        u_fetch.issue(exec_pkg::OP_SUBB, 8'h10, 8'h10);
        exp(3'h1, 1'b1, 1'b0, 1'b0, 8'h00, 16'h0101);
        ef = 8'h25;
        u_fetch.issue(exec_pkg::OP_SUBBK, 8'h00, 8'h00, 8'h01);
        exp(3'h1, 1'b1, 1'b0, 1'b0, 8'hff, 16'h0101);
    endtask

    // Logic ops keep C and H, clear V, set N and Z from the result
    task automatic t_logic;
        exec_pkg::op_e ops[5] = '{exec_pkg::OP_ANDK, exec_pkg::OP_ORK, exec_pkg::OP_SETB, exec_pkg::OP_CLRB,
                                  exec_pkg::OP_TEST};
        logic [7:0] r[5] = '{8'h00, 8'hff, 8'hff, 8'ha5, 8'ha5};
        for (int i = 0; i < 5; i++) begin
            u_fetch.issue(ops[i], 8'ha5, 8'h00, 8'h5a);
            ef = {ef[7:4], 1'b0, r[i][7], r[i] == 8'h00, ef[0]};
            exp(3'h1, i != 4, 1'b0, 1'b0, r[i], 16'h0101);
        end
    endtask

    task t_word;
        ef = 8'h23;
        u_fetch.issue(exec_pkg::OP_WADD, 8'hc1, 8'h00, 8'h3f, 3'h0, 7'h00, 16'h0000, 8'hff);
        exp(3'h2, 1'b1, 1'b1, 1'b0, 8'h00, 16'h0101);
        `CHK(res_hi_r, 8'h00)
        ef = 8'h38;
        u_fetch.issue(exec_pkg::OP_WSUB, 8'h00, 8'h00, 8'h01, 3'h0, 7'h00, 16'h0000, 8'h80);
        exp(3'h2, 1'b1, 1'b1, 1'b0, 8'hff, 16'h0101);
        `CHK(res_hi_r, 8'h7f)
    endtask

    task t_branch;
        u_fetch.issue(exec_pkg::OP_BRSET, 8'h00, 8'h00, 8'h00, 3'h4, 7'h7e);
        exp(3'h2, 1'b0, 1'b0, 1'b0, 8'h00, 16'h00ff);
        u_fetch.issue(exec_pkg::OP_BRCLR, 8'h00, 8'h00, 8'h00, 3'h3, 7'h05);
        exp(3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0101);
        u_fetch.issue(exec_pkg::OP_BRCLR, 8'h00, 8'h00, 8'h00, 3'h0, 7'h05);
        exp(3'h2, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0106);
    endtask

    // Skip table: operands, next-word length, clocks and landing address
    task automatic t_skip;
        exec_pkg::op_e ops[5] = '{exec_pkg::OP_CPSKIP, exec_pkg::OP_SKRC, exec_pkg::OP_SKRS, exec_pkg::OP_SKIC,
                                  exec_pkg::OP_SKIS};
        logic [7:0] a[5] = '{8'h3c, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] b[5] = '{8'h3c, 8'hf7, 8'hf7, 8'h00, 8'h00};
        logic [7:0] p[5] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h08};
        logic       tw[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        logic [2:0] l[5] = '{3'h3, 3'h2, 3'h1, 3'h1, 3'h3};
        for (int i = 0; i < 5; i++) begin
            u_fetch.issue(ops[i], a[i], b[i], 8'h00, 3'h3, 7'h00, 16'h0000, 8'h00, p[i], tw[i]);
            exp(l[i], 1'b0, 1'b0, 1'b0, 8'h00, 16'h0100 + {13'h0000, l[i]});
        end
    endtask

    task t_jump;
        u_fetch.issue(exec_pkg::OP_IJUMP, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 16'h1234);
        exp(3'h2, 1'b0, 1'b0, 1'b0, 8'h00, 16'h1234);
        u_fetch.issue(exec_pkg::OP_CALLZ, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 16'habcd);
        exp(3'h3, 1'b0, 1'b0, 1'b1, 8'h00, 16'habcd);
        `CHK(push_data_r, 16'h0101)
    endtask

    // Register forms the other scenarios leave out, then a no-operation
    task automatic t_reg;
        exec_pkg::op_e ops[8] = '{exec_pkg::OP_ADD, exec_pkg::OP_CPC, exec_pkg::OP_SUB, exec_pkg::OP_CP,
                                  exec_pkg::OP_EOR, exec_pkg::OP_AND, exec_pkg::OP_OR, exec_pkg::OP_NOP};
        logic [7:0] a[8] = '{8'hff, 8'h00, 8'h35, 8'h10, 8'ha5, 8'hf0, 8'h80, 8'h00};
        logic [7:0] b[8] = '{8'h01, 8'h00, 8'h35, 8'h20, 8'ha5, 8'h3c, 8'h01, 8'h00};
        logic [7:0] f[8] = '{8'h33, 8'h35, 8'h12, 8'h15, 8'h13, 8'h11, 8'h15, 8'h15};
        logic [7:0] r[8] = '{8'h00, 8'hff, 8'h00, 8'hf0, 8'h00, 8'h30, 8'h81, 8'h00};
        for (int i = 0; i < 8; i++) begin
            u_fetch.issue(ops[i], a[i], b[i]);
            ef = f[i];
            exp(3'h1, !(i inside {1, 3, 7}), 1'b0, 1'b0, r[i], 16'h0101);
        end
    endtask

    // Reset, then the scenarios in flag order
    initial begin
        rst = 1'b1;
        checks = 0;
        miscompares = 0;
        ef = 8'h00;
        repeat (12) @(posedge core_clk);
        #1 rst = 1'b0;
        `CHK({ready, done_r, res_we_r, push_we_r, flags_r, pc_new_r}, {4'h8, 8'h00, 16'h0000})
        t_arith;
        t_logic;
        t_word;
        t_branch;
        t_skip;
        t_jump;
        t_reg;
        give_verdict;
    end
endmodule

`default_nettype wire
